/* gcr_pkg.sv */
package gcr_pkg;
    localparam logic [7:0] ADDR_ANA_HI = 8'h00;
    localparam logic [7:0] ADDR_ANA_LO = 8'h01;
    localparam logic [7:0] ADDR_PIN3 = 8'h02;
    localparam logic [7:0] ADDR_PIN0 = 8'h05;
    localparam logic [7:0] ADDR_CKOUT = 8'h06;
    localparam logic [7:0] ADDR_CLKTEST = 8'hB4;
    localparam logic [7:0] ADDR_STATUS = 8'hF0;

    localparam logic [7:0] RST_ANA_HI = 8'h0C;
    localparam logic [7:0] RST_ANA_LO = 8'hC0;
    localparam logic [7:0] RST_PIN_GND = 8'hA2;
    localparam logic [7:0] RST_PIN0 = 8'h0A;
    localparam logic [7:0] RST_CKOUT = 8'h00;
    localparam logic [7:0] RST_CLKTEST = 8'h21;

    localparam int BLD_LSB = 0;
    localparam int GM_LSB = 2;
    localparam int XSEL_BIT = 6;
    localparam int AES_BIT = 5;
    localparam int EXTREF_BIT = 4;
    localparam int BROWN_BIT = 2;
    localparam int BATT_BIT = 1;
    localparam int TS_BIT = 0;
    localparam int PMODE_LSB = 0;
    localparam int PSEL_LSB = 3;
    localparam int CK_EN_BIT = 7;
    localparam int TAIL_LSB = 5;
    localparam int XRATIO_LSB = 1;
    localparam int RRATIO_BIT = 0;
    localparam int PD_BIT = 3;
    localparam int ST_STBY_BIT = 0;
    localparam int ST_STOP_BIT = 1;

    localparam logic [1:0] MODE_ANALOG = 2'h0;
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [9:0] TAIL_64 = 10'h040;
    localparam logic [9:0] TAIL_256 = 10'h100;
    localparam logic [9:0] TAIL_512 = 10'h200;
    localparam logic [6:0] RC_DIV_LAST = 7'h7F;

    typedef enum logic [1:0] {gcr_ph_cmd, gcr_ph_addr, gcr_ph_data} gcr_spi_ph_t;
    typedef enum logic [1:0] {gcr_ck_run, gcr_ck_tail, gcr_ck_stop} gcr_ck_st_t;
endpackage

/* gcr_mcu_clk.sv */
`timescale 1ns/1ps
`default_nettype none
module gcr_mcu_clk
    import gcr_pkg::*;
#(
    parameter int TAIL_W = 10
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_enable,
    input wire logic clk_powerdown,
    input wire logic xo_active,
    input wire logic sleep_mode,
    input wire logic standby_req,
    input wire logic rco_tick,
    input wire logic [1:0] tail_sel,
    input wire logic [3:0] crystal_clock_divider,
    input wire logic rc_clock_divider,
    output logic mcu_clk_tick,
    output logic standby_event,
    output logic clock_stopped
);
    if (TAIL_W < 10) begin : g_chk
        $error("TAIL_W too small for 512 tail cycles");
    end

    typedef struct packed {
        gcr_ck_st_t st;
        logic [7:0] acc;
        logic [6:0] rc_cnt;
        logic src_rc;
        logic [TAIL_W-1:0] tail_cnt;
        logic tick;
        logic event_p;
    } gcr_ck_state_t;

    gcr_ck_state_t s, n;

    // Ratio as numerator and denominator; the accumulator spreads 2/3 evenly
    function automatic logic [15:0] ratio_nd(input logic [3:0] code);
        logic [15:0] r;
        r = 16'h0101;
        unique case (code)
            4'h0: r = 16'h0101;
            4'h1: r = 16'h0203;
            4'h2: r = 16'h0102;
            4'h3: r = 16'h0103;
            4'h4: r = 16'h0104;
            4'h5: r = 16'h0106;
            4'h6: r = 16'h0108;
            4'h7: r = 16'h010C;
            4'h8: r = 16'h0110;
            4'h9: r = 16'h0118;
            4'hA: r = 16'h0124;
            4'hB: r = 16'h0130;
            4'hC: r = 16'h0140;
            4'hD: r = 16'h0160;
            4'hE: r = 16'h0180;
            4'hF: r = 16'h01C0;
        endcase
        return r;
    endfunction

    function automatic logic [TAIL_W-1:0] tail_len(input logic [1:0] sel);
        logic [9:0] t;
        t = 10'h000;
        unique case (sel)
            2'h0: t = 10'h000;
            2'h1: t = TAIL_64;
            2'h2: t = TAIL_256;
            2'h3: t = TAIL_512;
        endcase
        return TAIL_W'(t);
    endfunction

    logic running;
    logic t_raw;
    logic [8:0] acc_sum;
    logic [15:0] nd;

    always_comb begin
        n = s;
        n.event_p = 1'b0;
        nd = ratio_nd(crystal_clock_divider);
        acc_sum = {1'b0, s.acc} + {1'b0, nd[15:8]};
        t_raw = 1'b0;
        // Source only moves on an RC tick so the output never gets a runt pulse
        if (rco_tick) begin
            n.src_rc = sleep_mode & ~xo_active;
        end
        running = clk_enable & ~clk_powerdown & (s.st != gcr_ck_stop);
        if (running) begin
            if (!s.src_rc) begin
                if (acc_sum >= {1'b0, nd[7:0]}) begin
                    t_raw = 1'b1;
                    n.acc = 8'(acc_sum - {1'b0, nd[7:0]});
                end else begin
                    n.acc = acc_sum[7:0];
                end
            end else if (rco_tick) begin
                if (!rc_clock_divider || s.rc_cnt == RC_DIV_LAST) begin
                    t_raw = 1'b1;
                    n.rc_cnt = 7'h00;
                end else begin
                    n.rc_cnt = 7'(s.rc_cnt + 7'h01);
                end
            end
        end
        n.tick = t_raw;
        unique case (s.st)
            gcr_ck_run: begin
                if (standby_req) begin
                    n.event_p = 1'b1;
                    n.tail_cnt = tail_len(tail_sel);
                    n.st = (tail_len(tail_sel) == '0) ? gcr_ck_stop : gcr_ck_tail;
                end
            end
            gcr_ck_tail: begin
                if (t_raw) begin
                    n.tail_cnt = TAIL_W'(s.tail_cnt - 1'b1);
                    if (s.tail_cnt == TAIL_W'(1)) begin
                        n.st = gcr_ck_stop;
                    end
                end
            end
            gcr_ck_stop: begin
                if (!standby_req) begin
                    n.st = gcr_ck_run;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: gcr_ck_run, default: '0};
        end else begin
            s <= n;
        end
    end

    assign mcu_clk_tick = s.tick;
    assign standby_event = s.event_p;
    assign clock_stopped = (s.st == gcr_ck_stop);

    chk_standby_notify: assert property (@(posedge mclk) disable iff (!resetn)
        (s.st == gcr_ck_run && standby_req) |=> standby_event)
        else $error("standby entry not notified");
    chk_powerdown_stop: assert property (@(posedge mclk) disable iff (!resetn)
        clk_powerdown |=> !mcu_clk_tick)
        else $error("tick while dividers powered down");
    chk_src_on_rc: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(s.src_rc) |-> $past(rco_tick))
        else $error("source switched off an RC tick");
    chk_xo_undivided: assert property (@(posedge mclk) disable iff (!resetn)
        (running && !s.src_rc && crystal_clock_divider == 4'h0) |=> mcu_clk_tick)
        else $error("ratio 1 missed a tick");
    chk_tail_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (s.st == gcr_ck_run && standby_req && tail_sel == 2'h0) |=> clock_stopped)
        else $error("zero tail did not stop at once");
    cov_tail_done: cover property (@(posedge mclk) disable iff (!resetn)
        s.st == gcr_ck_tail ##1 s.st == gcr_ck_stop);
    cov_rc_src: cover property (@(posedge mclk) disable iff (!resetn) s.src_rc && s.tick);
endmodule
`default_nettype wire

/* gcr_general_config.sv */
`timescale 1ns/1ps
`default_nettype none
module gcr_general_config
    import gcr_pkg::*;
#(
    parameter int PIN_COUNT = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic xo_active,
    input wire logic sleep_mode,
    input wire logic standby_req,
    input wire logic rco_tick,
    output logic [1:0] low_battery_threshold,
    output logic [2:0] osc_driver_strength,
    output logic crystal_freq_select,
    output logic encrypt_enable,
    output logic external_reference_select,
    output logic brownout_detect_enable,
    output logic battery_level_enable,
    output logic temp_sensor_enable,
    output logic [7:0] pin_mode,
    output logic [19:0] pin_select,
    output logic clock_divider_powerdown,
    output logic mcu_clk_tick,
    output logic standby_irq
);
    if (PIN_COUNT != 4) begin : g_chk
        $error("register map holds exactly four pin registers");
    end

    typedef struct packed {
        logic [7:0] ana_hi;
        logic [7:0] ana_lo;
        logic [3:0][7:0] pin;
        logic [7:0] ck;
        logic [7:0] test;
        logic stby_flag;
        gcr_spi_ph_t ph;
        logic sclk_q;
        logic [2:0] bitcnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic rd;
        logic [7:0] addr;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic miso;
        logic miso_oe;
    } gcr_top_st_t;

    gcr_top_st_t s, n;
    logic standby_event;
    logic clock_stopped;
    logic commit_now;
    logic rd_stat_hit;

    function automatic logic is_pin(input logic [7:0] a);
        return (a >= ADDR_PIN3) && (a <= ADDR_PIN0);
    endfunction

    // Pin registers run downward in address: 0x02 is pin3, 0x05 is pin0
    function automatic logic [1:0] pin_idx(input logic [7:0] a);
        return 2'(ADDR_PIN0 - a);
    endfunction

    function automatic logic [7:0] rd_byte(input gcr_top_st_t t, input logic [7:0] a,
                                           input logic stopped);
        logic [7:0] d;
        d = 8'h00;
        if (a == ADDR_ANA_HI) begin
            d = t.ana_hi;
        end else if (a == ADDR_ANA_LO) begin
            d = t.ana_lo;
        end else if (is_pin(a)) begin
            d = t.pin[pin_idx(a)];
        end else if (a == ADDR_CKOUT) begin
            d = t.ck;
        end else if (a == ADDR_CLKTEST) begin
            d = t.test;
        end else if (a == ADDR_STATUS) begin
            d[ST_STBY_BIT] = t.stby_flag;
            d[ST_STOP_BIT] = stopped;
        end
        return d;
    endfunction

    // Reserved bits are stored as written; the host is trusted to keep them
    function automatic gcr_top_st_t apply_wr(input gcr_top_st_t t, input logic [7:0] a,
                                            input logic [7:0] d);
        gcr_top_st_t r;
        r = t;
        if (a == ADDR_ANA_HI) begin
            r.ana_hi = d;
        end else if (a == ADDR_ANA_LO) begin
            r.ana_lo = d;
        end else if (is_pin(a)) begin
            r.pin[pin_idx(a)][7:2] = d[7:2];
            // Analog mode exists only on pin0; elsewhere the old mode stays
            if (a == ADDR_PIN0 || d[PMODE_LSB +: 2] != MODE_ANALOG) begin
                r.pin[pin_idx(a)][PMODE_LSB +: 2] = d[PMODE_LSB +: 2];
            end
        end else if (a == ADDR_CKOUT) begin
            r.ck = d;
        end else if (a == ADDR_CLKTEST) begin
            r.test = d;
        end
        return r; // Status and unmapped addresses drop the write
    endfunction

    logic rise;
    logic fall;
    logic [7:0] byte_in;

    always_comb begin
        n = s;
        commit_now = 1'b0;
        rd_stat_hit = 1'b0;
        n.sclk_q = spi_sclk;
        rise = spi_sclk & ~s.sclk_q;
        fall = ~spi_sclk & s.sclk_q;
        byte_in = {s.sh_in[6:0], spi_mosi};
        if (spi_csn) begin
            n.ph = gcr_ph_cmd;
            n.bitcnt = 3'h0;
            n.rd = 1'b0;
            n.miso = 1'b0;
            n.miso_oe = 1'b0;
            if (s.wr_pend) begin
                n = apply_wr(n, s.wr_addr, s.wr_data);
                n.wr_pend = 1'b0;
                commit_now = 1'b1;
            end
        end else begin
            if (rise) begin
                n.sh_in = byte_in;
                n.bitcnt = 3'(s.bitcnt + 3'h1);
                if (s.bitcnt == 3'h7) begin
                    unique case (s.ph)
                        gcr_ph_cmd: begin
                            n.rd = (byte_in == CMD_READ);
                            n.ph = gcr_ph_addr;
                        end
                        gcr_ph_addr: begin
                            n.addr = byte_in;
                            n.ph = gcr_ph_data;
                            if (s.rd) begin
                                n.sh_out = rd_byte(s, byte_in, clock_stopped);
                                rd_stat_hit = (byte_in == ADDR_STATUS);
                            end
                        end
                        gcr_ph_data: begin
                            n.addr = 8'(s.addr + 8'h01);
                            if (s.rd) begin
                                n.sh_out = rd_byte(s, 8'(s.addr + 8'h01), clock_stopped);
                                rd_stat_hit = (8'(s.addr + 8'h01) == ADDR_STATUS);
                            end else begin
                                // A burst lands each byte once the next one is in; the last byte lands at deselect
                                if (s.wr_pend) begin
                                    n = apply_wr(n, s.wr_addr, s.wr_data);
                                    commit_now = 1'b1;
                                end
                                n.wr_pend = 1'b1;
                                n.wr_addr = s.addr;
                                n.wr_data = byte_in;
                            end
                        end
                    endcase
                end
            end
            // Mode 0: shift out on the falling edge for the host to sample on rise
            if (fall && s.rd && s.ph == gcr_ph_data) begin
                n.miso = s.sh_out[7];
                n.sh_out = {s.sh_out[6:0], 1'b0};
            end
            n.miso_oe = s.rd && (s.ph == gcr_ph_data);
        end
        if (rd_stat_hit) begin
            n.stby_flag = 1'b0;
        end
        // Set after clear, so an event in the read cycle survives
        if (standby_event) begin
            n.stby_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '{ana_hi: RST_ANA_HI, ana_lo: RST_ANA_LO,
                   pin: {RST_PIN_GND, RST_PIN_GND, RST_PIN_GND, RST_PIN0},
                   ck: RST_CKOUT, test: RST_CLKTEST, ph: gcr_ph_cmd, default: '0};
        end else begin
            s <= n;
        end
    end

    gcr_mcu_clk #(
        .TAIL_W(10)
    ) u_mcu_clk (
        .mclk(mclk),
        .resetn(resetn),
        .clk_enable(s.ck[CK_EN_BIT]),
        .clk_powerdown(s.test[PD_BIT]),
        .xo_active(xo_active),
        .sleep_mode(sleep_mode),
        .standby_req(standby_req),
        .rco_tick(rco_tick),
        .tail_sel(s.ck[TAIL_LSB +: 2]),
        .crystal_clock_divider(s.ck[XRATIO_LSB +: 4]),
        .rc_clock_divider(s.ck[RRATIO_BIT]),
        .mcu_clk_tick(mcu_clk_tick),
        .standby_event(standby_event),
        .clock_stopped(clock_stopped)
    );

    assign spi_miso = s.miso;
    assign spi_miso_oe = s.miso_oe;
    assign low_battery_threshold = s.ana_hi[BLD_LSB +: 2];
    assign osc_driver_strength = s.ana_hi[GM_LSB +: 3];
    assign crystal_freq_select = s.ana_lo[XSEL_BIT];
    assign encrypt_enable = s.ana_lo[AES_BIT];
    assign external_reference_select = s.ana_lo[EXTREF_BIT];
    assign brownout_detect_enable = s.ana_lo[BROWN_BIT];
    assign battery_level_enable = s.ana_lo[BATT_BIT];
    assign temp_sensor_enable = s.ana_lo[TS_BIT];
    assign clock_divider_powerdown = s.test[PD_BIT];
    assign standby_irq = s.stby_flag;

    for (genvar i = 0; i < 4; i++) begin : g_pin
        assign pin_mode[2*i +: 2] = s.pin[i][PMODE_LSB +: 2];
        assign pin_select[5*i +: 5] = s.pin[i][PSEL_LSB +: 5];
    end

    logic seen_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
        end
    end

    chk_reset_analog: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (low_battery_threshold == 2'h0 && osc_driver_strength == 3'h3))
        else $error("analog byte 0 reset wrong");
    chk_reset_drive: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (s.ana_hi == RST_ANA_HI && s.ana_lo == RST_ANA_LO))
        else $error("analog config reset wrong");
    chk_reset_enables: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (crystal_freq_select && !encrypt_enable && !external_reference_select
                     && !brownout_detect_enable && !temp_sensor_enable))
        else $error("enable bits reset wrong");
    chk_reset_pins: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (pin_select[19:5] == {3{5'h14}} && pin_mode[7:2] == 6'h2A))
        else $error("pins 3..1 reset wrong");
    chk_reset_pin0: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (pin_select[4:0] == 5'h01 && pin_mode[1:0] == 2'h2))
        else $error("pin0 reset wrong");
    chk_reset_clock: assert property (@(posedge mclk) disable iff (!resetn)
        !seen_r |-> (s.ck == RST_CKOUT && !clock_divider_powerdown))
        else $error("clock config reset wrong");
    chk_status_clear: assert property (@(posedge mclk) disable iff (!resetn)
        (rd_stat_hit && !standby_event) |=> !standby_irq)
        else $error("status not cleared by read");
    chk_event_wins: assert property (@(posedge mclk) disable iff (!resetn)
        standby_event |=> standby_irq)
        else $error("standby event lost");
    chk_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
        (commit_now && s.wr_addr == ADDR_CKOUT) |=> (s.ck == $past(s.wr_data)))
        else $error("write did not land");
    chk_ro_ignore: assert property (@(posedge mclk) disable iff (!resetn)
        (commit_now && s.wr_addr == ADDR_STATUS && !standby_event && !rd_stat_hit)
        |=> $stable(standby_irq))
        else $error("read-only status took a write");
    chk_pin_analog: assert property (@(posedge mclk) disable iff (!resetn)
        (commit_now && s.wr_addr == ADDR_PIN3 && s.wr_data[1:0] == MODE_ANALOG)
        |=> $stable(pin_mode[7:6]))
        else $error("analog mode accepted on pin3");
    chk_miso_idle: assert property (@(posedge mclk) disable iff (!resetn)
        spi_csn |=> !spi_miso_oe)
        else $error("miso driven while deselected");

    cov_write_commit: cover property (@(posedge mclk) disable iff (!resetn) commit_now);
    cov_status_read: cover property (@(posedge mclk) disable iff (!resetn) rd_stat_hit);
    cov_standby: cover property (@(posedge mclk) disable iff (!resetn) standby_event);
endmodule
`default_nettype wire

/* gcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model (
    input wire logic mclk,
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Three mclk per phase keeps sclk above the two-sample minimum
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            gap(3);
            rx[i] = spi_miso;
            spi_sclk = 1'b1;
            gap(3);
            spi_sclk = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [7:0] junk;
        gap(1);
        spi_csn = 1'b0;
        gap(3);
        shift(cmd, junk);
        shift(adr, junk);
        shift(wd, rd);
        gap(3);
        spi_csn = 1'b1;
        // Idle line toggles so a stale bit never looks like data
        spi_mosi = ~spi_mosi;
        gap(4);
    endtask
endmodule
`default_nettype wire

/* gcr_general_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module gcr_general_config_bench;
    import gcr_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, standby_req = 1'b0;
    logic spi_sclk, spi_csn, spi_mosi, spi_miso, crystal_freq_select, encrypt_enable;
    logic external_reference_select, brownout_detect_enable, battery_level_enable;
    logic temp_sensor_enable, clock_divider_powerdown, mcu_clk_tick, standby_irq;
    logic [1:0] low_battery_threshold;
    logic [2:0] osc_driver_strength;
    logic [7:0] pin_mode, rd;
    logic [19:0] pin_select;
    logic xo_active = 1'b1, sleep_mode = 1'b0, rco_tick = 1'b0, spi_miso_oe;
    int miscompares = 0, check_count = 0, n, rc_div = 0;
    always #12.5 mclk = ~mclk;
    // RC oscillator edge once every four mclk, changed off the sampling edge
    always @(posedge mclk) begin
        #2;
        rc_div = (rc_div + 1) % 4;
        rco_tick = (rc_div == 0);
    end
    gcr_host_model u_host (.mclk, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso);
    gcr_general_config u_dut (.mclk, .resetn, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso,
        .spi_miso_oe, .xo_active, .sleep_mode, .standby_req, .rco_tick,
        .low_battery_threshold, .osc_driver_strength, .crystal_freq_select, .encrypt_enable,
        .external_reference_select, .brownout_detect_enable, .battery_level_enable,
        .temp_sensor_enable, .pin_mode, .pin_select, .clock_divider_powerdown, .mcu_clk_tick,
        .standby_irq);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(8'h00, a, d, rd);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.xfer(CMD_READ, a, 8'h00, rd);
        check({24'h0, rd}, {24'h0, e});
        check(spi_miso_oe, 1'b0);
    endtask
    task automatic count(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #2;
            if (mcu_clk_tick === 1'b1) n++;
        end
    endtask
    task automatic t_reset;
        logic [7:0] a[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hB4};
        logic [7:0] e[8] = '{RST_ANA_HI, RST_ANA_LO, RST_PIN_GND, RST_PIN_GND, RST_PIN_GND,
                              RST_PIN0, RST_CKOUT, RST_CLKTEST};
        check({pin_select, pin_mode, osc_driver_strength}, {20'hA5281, 8'hAA, 3'h3});
        for (int i = 0; i < 8; i++) rd_chk(a[i], e[i]);
        $display("reset values done");
    endtask
    task automatic t_regs;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_ANA_HI, 8'h0C | 8'(c));
            check(low_battery_threshold, c[1:0]);
            rd_chk(ADDR_ANA_HI, 8'h0C | 8'(c));
        end
        wr(ADDR_ANA_LO, 8'hB7);
        check({crystal_freq_select, encrypt_enable, external_reference_select,
               brownout_detect_enable, battery_level_enable, temp_sensor_enable}, 6'h1F);
        rd_chk(ADDR_ANA_LO, 8'hB7);
        wr(ADDR_STATUS, 8'hFF);
        rd_chk(ADDR_STATUS, 8'h00);
        $display("register access done");
    endtask
    task automatic t_pins;
        wr(ADDR_PIN3, 8'h18);
        check({pin_select[19:15], pin_mode[7:6]}, {5'h03, 2'h2});
        rd_chk(ADDR_PIN3, 8'h1A);
        wr(ADDR_PIN0, 8'h08);
        check(pin_mode[1:0], MODE_ANALOG);
        $display("pin modes done");
    endtask
    task automatic t_clock;
        int e[10] = '{192, 128, 96, 64, 48, 32, 24, 16, 12, 8};
        // Accumulator phase allows one tick either way in a window
        for (int c = 0; c < 10; c++) begin
            wr(ADDR_CKOUT, {3'b100, 4'(c), 1'b0});
            count(192);
            check(32'(n >= e[c] - 1 && n <= e[c] + 1), 32'h1);
        end
        wr(ADDR_CLKTEST, 8'h29);
        count(50);
        check({clock_divider_powerdown, 8'(n)}, 9'h100);
        wr(ADDR_CLKTEST, RST_CLKTEST);
        wr(ADDR_CKOUT, 8'hA0);
        standby_req = 1'b1;
        count(700);
        check(32'(n >= 64 && n <= 66 && standby_irq === 1'b1), 32'h1);
        rd_chk(ADDR_STATUS, 8'h03);
        check(standby_irq, 1'b0);
        rd_chk(ADDR_STATUS, 8'h02);
        standby_req = 1'b0;
        wr(ADDR_CKOUT, 8'h00);
        count(20);
        check(n, 0);
        $display("host clock done");
    endtask
    task automatic t_rc;
        wr(ADDR_CKOUT, 8'h80);
        xo_active = 1'b0;
        sleep_mode = 1'b1;
        count(8);
        count(40);
        check(32'(n >= 9 && n <= 11), 32'h1);
        wr(ADDR_CKOUT, 8'h81);
        count(600);
        check(32'(n >= 1 && n <= 2), 32'h1);
        xo_active = 1'b1;
        sleep_mode = 1'b0;
        wr(ADDR_CKOUT, 8'h80);
        count(8);
        count(40);
        check(32'(n >= 39 && n <= 40), 32'h1);
        $display("rc source done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #2 resetn = 1'b1;
        t_reset();
        t_regs();
        t_pins();
        resetn = 1'b0;
        u_host.gap(2);
        resetn = 1'b1;
        t_reset();
        t_clock();
        t_rc();
        complete_run();
    end
endmodule
`default_nettype wire
